//--- hw/fsl_defines.svh
// Constants for the fast shutoff block: sizes, offsets, fields, resets, timing
`ifndef FSL_DEFINES_SVH
`define FSL_DEFINES_SVH
// Sizes
`define FSL_NUM_IN        14
`define FSL_NUM_PAIR      6
`define FSL_NUM_OUT       2
`define FSL_DLY_W         16
`define FSL_ADDR_W        8
// Register byte offsets
`define FSL_OFS_CTRL      8'h00
`define FSL_OFS_STATUS    8'h04
`define FSL_OFS_IN_CFG    8'h08
`define FSL_OFS_MODE      8'h0c
`define FSL_OFS_MASK_BASE 8'h10
`define FSL_OFS_DLY_BASE  8'h40
`define FSL_OFS_IN_STATE  8'h80
// Field positions
`define FSL_CTRL_COMMIT   0
`define FSL_ST_PLAUS      0
`define FSL_ST_TRIP_LSB   8
`define FSL_ST_DRIVE_LSB  16
`define FSL_IN_DUAL_LSB   16
`define FSL_IN_ERR_LSB    16
// Reset values
`define FSL_RST_MASK      14'h0000
`define FSL_RST_DLY       16'h0000
`define FSL_RST_DUAL      6'h00
// Timing: delay unit of 1 ms at a 25 ns clock
`define FSL_CLK_PERIOD_NS 25
`define FSL_DLY_UNIT_NS   1000000
`define FSL_TICK_CYCLES   (`FSL_DLY_UNIT_NS / `FSL_CLK_PERIOD_NS)
`endif

//--- hw/fsl_pkg.sv
// Types shared by the fast shutoff block
package fsl_pkg;
  typedef logic [13:0] fsl_mask_t;  // One bit per candidate input
  typedef logic [15:0] fsl_dly_t;   // On-to-off delay in ms
endpackage

//--- hw/fsl_in_delay.sv
// Per-input qualifier applying the on-to-off delay
module fsl_in_delay (
  // Clock and control
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire logic           tick,
  // Input level and its delay
  input  wire logic           level,
  input  wire fsl_pkg::fsl_dly_t delay,
  // Qualified active state
  output logic                qual
);
  fsl_pkg::fsl_dly_t cnt_reg;  // Elapsed ms since fall
  logic              qual_reg; // Qualified state

  // High level is active at once; fall is seen after the delay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg  <= 16'h0000;
      qual_reg <= 1'b0;
    end else if (clk_en) begin
      if (level) begin
        cnt_reg  <= 16'h0000;
        qual_reg <= 1'b1;
      end else if (qual_reg) begin
        if (cnt_reg >= delay) begin
          qual_reg <= 1'b0;
        end else if (tick) begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end

  assign qual = qual_reg;
endmodule

//--- hw/fsl_out_ctl.sv
// Zone evaluation and shutoff latch for one safety output
module fsl_out_ctl (
  // Clock and control
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // Input health, active and error-free
  input  wire fsl_pkg::fsl_mask_t in_ok,
  // Configuration
  input  wire fsl_pkg::fsl_mask_t mask_a,
  input  wire fsl_pkg::fsl_mask_t mask_b,
  input  wire logic              two_zone,
  // Normal control command
  input  wire logic              ctrl_on,
  // Results
  output logic                   drive,
  output logic                   tripped
);
  fsl_pkg::fsl_mask_t cul_reg;    // Inputs that caused the trip
  fsl_pkg::fsl_mask_t cul_next;
  fsl_pkg::fsl_mask_t sel;        // All monitored inputs
  logic permit_reg, trip_reg, armed_reg, drive_reg;
  logic zone_a, zone_b, permit, trip, recovered, armed_next, trip_next;

  assign zone_a     = &(in_ok | ~mask_a);
  assign zone_b     = &(in_ok | ~mask_b);
  assign permit     = zone_a | (two_zone & zone_b);
  assign sel        = mask_a | (two_zone ? mask_b : 14'h0000);
  assign trip       = permit_reg & ~permit;
  assign recovered  = &(in_ok | ~cul_reg);
  // Off command seen since reset or since the trip
  assign armed_next = ~ctrl_on | (armed_reg & ~trip);
  // New trip wins over release
  assign trip_next  = trip | (trip_reg & ~(recovered & armed_next));
  assign cul_next   = trip_next ?
                      ((trip_reg ? cul_reg : 14'h0000) | (sel & ~in_ok)) : 14'h0000;

  // State update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      permit_reg <= 1'b0;
      trip_reg   <= 1'b0;
      armed_reg  <= 1'b0;
      drive_reg  <= 1'b0;
      cul_reg    <= 14'h0000;
    end else if (clk_en) begin
      permit_reg <= permit;
      trip_reg   <= trip_next;
      armed_reg  <= armed_next;
      cul_reg    <= cul_next;
      drive_reg  <= ctrl_on & armed_next & ~trip_next;
    end
  end

  assign drive   = drive_reg;
  assign tripped = trip_reg;
endmodule

//--- hw/fsl_top.sv
// Fast shutoff logic for all safety outputs with register port
// Function
// - Own shutoff unit for each safety output
// - Two independent zone columns per output
// - One selection bit per candidate input
// - Per-output choice of one or two zones
// - Zone result is AND of selected inputs
// - Two zones ORed; one zone uses first
// - Selected input fall or error forces off once no zone holds
// - Fall counts only after on-off delay
// - Stay off until culprits active, error free
// - Off command needed before next on
// - Inputs high active; only falling edge trips
// - Unconfigured selected input rejects configuration load
// - Dual-channel input selectable on channel A only
//
// Added by the designer: the register addresses and the strobed register port.
`include "fsl_defines.svh"
module fsl_top #(
  parameter int NUM_OUT     = `FSL_NUM_OUT,
  parameter int TICK_CYCLES = `FSL_TICK_CYCLES
) (
  // Clock, reset and enable
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // Register port
  input  wire logic [`FSL_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Safety input pins, 1A..6B then link 1..2
  input  wire logic [`FSL_NUM_IN-1:0] sens_in,
  // Error flags from input diagnostics
  input  wire logic [`FSL_NUM_IN-1:0] sens_err,
  // Commands from normal output control
  input  wire logic [NUM_OUT-1:0]     ctrl_on,
  // Output drive and trip state
  output logic      [NUM_OUT-1:0]     out_drive,
  output logic      [NUM_OUT-1:0]     out_tripped
);
  localparam int NI = `FSL_NUM_IN;

  // Refuse sizes the register map or the 16-bit prescaler count cannot hold
  generate
    if (NUM_OUT < 1 || NUM_OUT > 6) begin : g_bad_out
      $error("NUM_OUT must be 1 to 6");
    end
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
      $error("TICK_CYCLES must be 1 to 65536");
    end
  endgenerate

  // Input synchroniser stages
  logic [NI-1:0] sync1_reg;            // First stage, read only by second
  logic [NI-1:0] sync2_reg;            // Stable input levels

  // Millisecond tick
  logic [15:0]   tick_cnt_reg;         // Prescaler count
  logic          tick;                 // One-cycle ms pulse

  // Shadow configuration, written by software
  fsl_pkg::fsl_mask_t sh_a_reg [NUM_OUT];  // Zone 1 column
  fsl_pkg::fsl_mask_t sh_b_reg [NUM_OUT];  // Zone 2 column
  logic [NUM_OUT-1:0] sh_two_reg;          // Two-zone selection
  fsl_pkg::fsl_mask_t in_cfg_reg;          // Inputs that are configured
  logic [`FSL_NUM_PAIR-1:0] dual_reg;      // Pairs in dual-channel mode

  // Live configuration used by the shutoff units
  fsl_pkg::fsl_mask_t lv_a_reg [NUM_OUT];
  fsl_pkg::fsl_mask_t lv_b_reg [NUM_OUT];
  logic [NUM_OUT-1:0] lv_two_reg;

  // Delays and status
  fsl_pkg::fsl_dly_t  dly_reg [NI];        // Per-input on-off delay
  logic               plaus_reg;           // Sticky load rejection flag
  logic [31:0]        rdata_reg;           // Read data stage
  logic [31:0]        rdata_next;

  // Evaluated input state
  fsl_pkg::fsl_mask_t qual;                // Delay-qualified levels
  fsl_pkg::fsl_mask_t in_ok;               // Active with no error
  fsl_pkg::fsl_mask_t dual_b;              // Channel B of dual pairs
  fsl_pkg::fsl_mask_t bad_sel;             // Illegal selections found

  // Decoded register strobes
  wire wr_ctrl   = reg_wr && (reg_addr == `FSL_OFS_CTRL);
  wire wr_status = reg_wr && (reg_addr == `FSL_OFS_STATUS);
  wire wr_in_cfg = reg_wr && (reg_addr == `FSL_OFS_IN_CFG);
  wire wr_mode   = reg_wr && (reg_addr == `FSL_OFS_MODE);
  wire commit    = wr_ctrl && reg_wdata[`FSL_CTRL_COMMIT];
  wire plaus_clr = wr_status && reg_wdata[`FSL_ST_PLAUS];
  wire load_bad  = |bad_sel;
  wire load_ok   = commit && !load_bad;

  // Two-flop synchroniser for the pin inputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= 14'h0000;
      sync2_reg <= 14'h0000;
    end else if (clk_en) begin
      sync1_reg <= sens_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Prescaler giving one tick per millisecond
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // One delay qualifier per candidate input
  generate
    for (genvar i = 0; i < NI; i++) begin : g_in
      fsl_in_delay u_dly (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .tick     (tick),
        .level    (sync2_reg[i]),
        .delay    (dly_reg[i]),
        .qual     (qual[i])
      );
    end
  endgenerate

  // An input in error counts as inactive
  assign in_ok = qual & ~sens_err;

  // Channel B bits of pairs run in dual-channel mode
  generate
    for (genvar p = 0; p < `FSL_NUM_PAIR; p++) begin : g_pair
      assign dual_b[2*p]   = 1'b0;
      assign dual_b[2*p+1] = dual_reg[p];
    end
  endgenerate
  // Link inputs have no partner channel
  assign dual_b[NI-1:NI-2] = 2'b00;

  // Check the shadow columns before they go live
  always_comb begin
    bad_sel = 14'h0000;
    for (int o = 0; o < NUM_OUT; o++) begin
      bad_sel = bad_sel | ((sh_a_reg[o] | sh_b_reg[o]) & ~in_cfg_reg);
      bad_sel = bad_sel | ((sh_a_reg[o] | sh_b_reg[o]) & dual_b);
    end
  end

  // Global configuration registers and load
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_cfg_reg <= `FSL_RST_MASK;
      dual_reg   <= `FSL_RST_DUAL;
      sh_two_reg <= '0;
      lv_two_reg <= '0;
      plaus_reg  <= 1'b0;
    end else if (clk_en) begin
      // Configured inputs and dual pairs
      if (wr_in_cfg) begin
        in_cfg_reg <= reg_wdata[NI-1:0];
        dual_reg   <= reg_wdata[`FSL_IN_DUAL_LSB +: `FSL_NUM_PAIR];
      end
      // Zone count per output
      if (wr_mode) begin
        sh_two_reg <= reg_wdata[NUM_OUT-1:0];
      end
      // Load only a plausible configuration
      if (load_ok) begin
        lv_two_reg <= sh_two_reg;
      end
      // Rejection flag: a new rejection wins over the clear
      if (commit && load_bad) begin
        plaus_reg <= 1'b1;
      end else if (plaus_clr) begin
        plaus_reg <= 1'b0;
      end
    end
  end

  // Per-output columns, shadow and live
  generate
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_cfg
      wire [`FSL_ADDR_W-1:0] ofs_a = `FSL_OFS_MASK_BASE + 8'(8 * o);
      wire [`FSL_ADDR_W-1:0] ofs_b = `FSL_OFS_MASK_BASE + 8'(8 * o + 4);
      wire wr_a = reg_wr && (reg_addr == ofs_a);
      wire wr_b = reg_wr && (reg_addr == ofs_b);

      // Column storage
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sh_a_reg[o] <= `FSL_RST_MASK;
          sh_b_reg[o] <= `FSL_RST_MASK;
          lv_a_reg[o] <= `FSL_RST_MASK;
          lv_b_reg[o] <= `FSL_RST_MASK;
        end else if (clk_en) begin
          // Each column written on its own
          if (wr_a) begin
            sh_a_reg[o] <= reg_wdata[NI-1:0];
          end
          if (wr_b) begin
            sh_b_reg[o] <= reg_wdata[NI-1:0];
          end
          // Copy to live on a good load
          if (load_ok) begin
            lv_a_reg[o] <= sh_a_reg[o];
            lv_b_reg[o] <= sh_b_reg[o];
          end
        end
      end

      // Independent shutoff unit for this output
      fsl_out_ctl u_out (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .in_ok    (in_ok),
        .mask_a   (lv_a_reg[o]),
        .mask_b   (lv_b_reg[o]),
        .two_zone (lv_two_reg[o]),
        .ctrl_on  (ctrl_on[o]),
        .drive    (out_drive[o]),
        .tripped  (out_tripped[o])
      );
    end
  endgenerate

  // Per-input delay registers
  generate
    for (genvar i = 0; i < NI; i++) begin : g_dly
      wire wr_d = reg_wr && (reg_addr == `FSL_OFS_DLY_BASE + 8'(4 * i));

      // Delay storage
      always_ff @(posedge core_clk) begin
        if (rst) begin
          dly_reg[i] <= `FSL_RST_DLY;
        end else if (clk_en && wr_d) begin
          dly_reg[i] <= reg_wdata[`FSL_DLY_W-1:0];
        end
      end
    end
  endgenerate

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_addr == `FSL_OFS_STATUS) begin
      rdata_next[`FSL_ST_PLAUS] = plaus_reg;
      rdata_next[`FSL_ST_TRIP_LSB +: NUM_OUT]  = out_tripped;
      rdata_next[`FSL_ST_DRIVE_LSB +: NUM_OUT] = out_drive;
    end else if (reg_addr == `FSL_OFS_IN_CFG) begin
      rdata_next[NI-1:0] = in_cfg_reg;
      rdata_next[`FSL_IN_DUAL_LSB +: `FSL_NUM_PAIR] = dual_reg;
    end else if (reg_addr == `FSL_OFS_MODE) begin
      rdata_next[NUM_OUT-1:0] = sh_two_reg;
    end else if (reg_addr == `FSL_OFS_IN_STATE) begin
      rdata_next[NI-1:0] = qual;
      rdata_next[`FSL_IN_ERR_LSB +: NI] = sens_err;
    end else begin
      // Column and delay windows
      for (int o = 0; o < NUM_OUT; o++) begin
        if (reg_addr == `FSL_OFS_MASK_BASE + 8'(8 * o)) begin
          rdata_next[NI-1:0] = sh_a_reg[o];
        end else if (reg_addr == `FSL_OFS_MASK_BASE + 8'(8 * o + 4)) begin
          rdata_next[NI-1:0] = sh_b_reg[o];
        end
      end
      for (int i = 0; i < NI; i++) begin
        if (reg_addr == `FSL_OFS_DLY_BASE + 8'(4 * i)) begin
          rdata_next[`FSL_DLY_W-1:0] = dly_reg[i];
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_reg <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

//--- testbench/fsl_chk_sva.sv
// Port checker for the fast shutoff block
module fsl_chk #(
  parameter int NUM_OUT = 2
) (
  // Clock, reset, enable
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               clk_en,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  // Field side
  input wire logic [13:0]        sens_in,
  input wire logic [13:0]        sens_err,
  input wire logic [NUM_OUT-1:0] ctrl_on,
  input wire logic [NUM_OUT-1:0] out_drive,
  input wire logic [NUM_OUT-1:0] out_tripped
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain, idle in reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Status and input state reads taken
  wire logic rd_st = reg_rd && clk_en && (reg_addr == 8'h04);
  wire logic rd_in = reg_rd && clk_en && (reg_addr == 8'h80);
  property p_trip_off;
    out_tripped[0] |-> !out_drive[0];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("drive on while tripped");
  property p_off_cmd;
    (!ctrl_on[0] && clk_en) |=> !out_drive[0];
  endproperty
  a_off_cmd: assert property (p_off_cmd) else $error("drive on without command");
  property p_on_src;
    $rose(out_drive[0]) |-> $past(ctrl_on[0]);
  endproperty
  a_on_src: assert property (p_on_src) else $error("drive rose without command");
  // Trip taken under an on command, command held for three cycles from the rise
  property p_hold;
    ($rose(out_tripped[0]) && $past(ctrl_on[0])) ##0 (ctrl_on[0] && clk_en) [*3]
      |-> out_tripped[0];
  endproperty
  a_hold: assert property (p_hold) else $error("trip released under on command");
  property p_st_trip;
    rd_st |=> reg_rdata[8+:NUM_OUT] == $past(out_tripped);
  endproperty
  a_st_trip: assert property (p_st_trip) else $error("status trip bits wrong");
  property p_st_drv;
    rd_st |=> reg_rdata[16+:NUM_OUT] == $past(out_drive);
  endproperty
  a_st_drv: assert property (p_st_drv) else $error("status drive bits wrong");
  property p_in_err;
    rd_in |=> reg_rdata[29:16] == $past(sens_err);
  endproperty
  a_in_err: assert property (p_in_err) else $error("input error field wrong");
  property p_freeze;
    !clk_en |=> $stable(out_drive) && $stable(out_tripped) && $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  // Main scenarios reached
  c_trip: cover property ($rose(out_tripped[0]));
  c_on: cover property ($rose(out_drive[0]));
  c_rel: cover property ($fell(out_tripped[0]));
endmodule

bind fsl_top fsl_chk #(
  .NUM_OUT(NUM_OUT)
) u_chk (
  .core_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sens_in, .sens_err, .ctrl_on, .out_drive, .out_tripped
);

//--- testbench/fsl_field.sv
// Field model: sensor pins, diagnostics, normal output control
module fsl_field (
  // Requests from the bench
  input  wire logic [13:0] pin_q,
  input  wire logic [13:0] err_q,
  input  wire logic [1:0]  on_q,
  // Lines toward the block
  output logic      [13:0] sens_in,
  output logic      [13:0] sens_err,
  output logic      [1:0]  ctrl_on
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sensors drive high when active, off the clock edge
  assign #7 sens_in = pin_q;
  // Diagnostics in the block's clock
  assign sens_err = err_q;
  // Controller commands off before a new on
  assign ctrl_on = on_q;
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the fast shutoff block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Ordinary zone case
  typedef struct {
    logic [13:0] ma;
    logic [13:0] mb;
    logic        tz;
    logic [13:0] er;
    logic        d0;
  } fsl_row_s;
  // Masks, mode, errors, expected drive of output 0
  fsl_row_s rows [7] = '{
    '{14'h0001, 14'h0000, 1'b0, 14'h0001, 1'b0},
    '{14'h0005, 14'h0000, 1'b0, 14'h0004, 1'b0},
    '{14'h0001, 14'h0000, 1'b0, 14'h0002, 1'b1},
    '{14'h0001, 14'h0004, 1'b1, 14'h0001, 1'b1},
    '{14'h0001, 14'h0004, 1'b1, 14'h0005, 1'b0},
    '{14'h0001, 14'h0004, 1'b0, 14'h0001, 1'b0},
    '{14'h2000, 14'h0000, 1'b0, 14'h2000, 1'b0}
  };
  logic        core_clk;
  logic        rst;
  logic        clk_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [13:0] pin_q;
  logic [13:0] err_q;
  logic [1:0]  on_q;
  logic [13:0] sens_in;
  logic [13:0] sens_err;
  logic [1:0]  ctrl_on;
  logic [1:0]  out_drive;
  logic [1:0]  out_tripped;
  logic [31:0] v;
  int          miscompares;
  int          check_count;
  // Design with a short ms tick
  fsl_top #(.NUM_OUT(2), .TICK_CYCLES(4)) uut (
    .core_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sens_in, .sens_err, .ctrl_on, .out_drive, .out_tripped
  );
  // Sensors and controller
  fsl_field u_field (.pin_q, .err_q, .on_q, .sens_in, .sens_err, .ctrl_on);
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  // Register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Trip and drive state as {tripped, drive}
  task automatic look(input logic [3:0] e);
    @(negedge core_clk);
    chk({28'h0, out_tripped, out_drive}, {28'h0, e});
    @(posedge core_clk);
  endtask
  // Verdict and end of run
  task automatic close_out;
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    cyc(5000);
    miscompares++;
    close_out;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pin_q = 14'h3fff;
    err_q = 14'h0;
    on_q = 2'h3;
    cyc(8);
    rst <= 1'b0;
    cyc(5);
    look(4'h0);
    rd(8'h10);
    chk(v, 32'h0);
    rd(8'h40);
    chk(v, 32'h0);
    rd(8'hfc);
    chk(v, 32'h0);
    wr(8'h08, 32'h3fff);
    on_q <= 2'h0;
    cyc(2);
    on_q <= 2'h3;
    cyc(3);
    look(4'h3);
    foreach (rows[i]) begin
      wr(8'h10, {18'h0, rows[i].ma});
      wr(8'h14, {18'h0, rows[i].mb});
      wr(8'h0c, {31'h0, rows[i].tz});
      wr(8'h00, 32'h1);
      err_q <= rows[i].er;
      cyc(3);
      look({1'b0, !rows[i].d0, 1'b1, rows[i].d0});
      err_q <= 14'h0;
      on_q <= 2'h2;
      cyc(2);
      on_q <= 2'h3;
      cyc(3);
      look(4'h3);
    end
    // Unconfigured input selected: load refused
    wr(8'h08, 32'h3ffe);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1);
    rd(8'h04);
    chk(v & 32'h1, 32'h1);
    err_q <= 14'h0001;
    cyc(2);
    look(4'h3);
    err_q <= 14'h0;
    wr(8'h04, 32'h1);
    rd(8'h04);
    chk(v & 32'h1, 32'h0);
    // Dual pair: channel B refused, channel A taken
    wr(8'h08, 32'h1_3fff);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h1);
    rd(8'h04);
    chk(v & 32'h1, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1);
    rd(8'h04);
    chk(v, 32'h0003_0000);
    // Pin fall after a 2 ms delay, then recovery
    wr(8'h40, 32'h2);
    pin_q[0] <= 1'b0;
    cyc(4);
    look(4'h3);
    cyc(12);
    look(4'h6);
    pin_q[0] <= 1'b1;
    cyc(6);
    look(4'h6);
    on_q <= 2'h2;
    cyc(2);
    look(4'h2);
    on_q <= 2'h3;
    cyc(2);
    look(4'h3);
    // Frozen, then error trips at once
    clk_en <= 1'b0;
    err_q <= 14'h0001;
    cyc(3);
    look(4'h3);
    clk_en <= 1'b1;
    cyc(2);
    look(4'h6);
    rd(8'h80);
    chk(v, 32'h0001_3fff);
    err_q <= 14'h0;
    on_q <= 2'h2;
    cyc(2);
    on_q <= 2'h3;
    cyc(2);
    // Second output trips alone
    wr(8'h18, 32'h20);
    wr(8'h00, 32'h1);
    err_q <= 14'h0020;
    cyc(3);
    look(4'h9);
    // Reset in mid-run: outputs off, configuration cleared
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    look(4'h0);
    rd(8'h18);
    chk(v, 32'h0);
    rd(8'h04);
    chk(v, 32'h0);
    close_out;
  end
endmodule
